// >>> rtl/mie_pkg.sv
// Package for the interrupt enable and flag block: offsets, fields, types
// Function
// - Each flag sets on its event, ignoring its enable and the global enable.
// - Core control register answers at four mirrored addresses, one storage.
// - Core control register is fully readable and writable by software.
// - Bit 7 is the global enable; clear blocks every interrupt.
// - Bit 6 gates all peripheral interrupts.
// - Peripheral enable register sits at one address, one bit per source.
// - Enable bit 6 unmasks the conversion-done interrupt.
// - Enable bit 3 unmasks the serial port interrupt.
// - Enable bit 0 unmasks the timer-one overflow interrupt.
// - Bit 2 gates capture/compare, bit 1 gates timer-two match.
// - Peripheral enable bits 7, 5, 4 read zero and ignore writes.
// - Edge select picks rising (1) or falling (0) external pin edge.
// - Peripheral flags live in their own register, same bit positions.
package mie_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [8:0] CORE_CTRL_IDX0 = 9'h00b;
	localparam logic [8:0] CORE_CTRL_IDX1 = 9'h08b;
	localparam logic [8:0] CORE_CTRL_IDX2 = 9'h10b;
	localparam logic [8:0] CORE_CTRL_IDX3 = 9'h18b;
	localparam logic [8:0] PERIPH_EN_IDX  = 9'h08c;
	localparam logic [8:0] PERIPH_FLG_IDX = 9'h00c;
	localparam logic [8:0] EDGE_SEL_IDX   = 9'h081;

	// Core control register fields
	localparam int GIE_BIT    = 7;
	localparam int PGATE_BIT  = 6;
	localparam int T0E_BIT    = 5;
	localparam int EXTE_BIT   = 4;
	localparam int PCE_BIT    = 3;
	localparam int T0F_BIT    = 2;
	localparam int EXTF_BIT   = 1;
	localparam int PCF_BIT    = 0;

	// Peripheral enable/flag fields
	localparam int ADC_BIT    = 6;
	localparam int SSP_BIT    = 3;
	localparam int CCP_BIT    = 2;
	localparam int T2_BIT     = 1;
	localparam int T1_BIT     = 0;
	localparam logic [7:0] PERIPH_MASK = 8'h4f;

	// Reset values
	localparam logic [7:0] CORE_CTRL_RST = 8'h00;
	localparam logic [7:0] PERIPH_RST    = 8'h00;
	localparam logic       EDGE_SEL_RST  = 1'b1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Peripheral event strobes, one bit per source
	typedef struct packed {
		logic conv_done;
		logic serial_port;
		logic capture_compare;
		logic timer_two_match;
		logic timer_one_overflow;
	} mie_periph_evt_t;

endpackage

// >>> rtl/mie_irq_ctrl.sv
// Interrupt enable and flag registers with AXI4-Lite slave
//
// Register access over AXI4-Lite was chosen for this implementation.
module mie_irq_ctrl #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]        s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Event sources
	input  wire logic                     timer_zero_overflow,
	input  wire logic                     external_irq_pin,
	input  wire logic                     port_mismatch,
	input  wire mie_pkg::mie_periph_evt_t periph_evt,
	// Core request
	output logic                          irq_request
);

	logic [7:0]  core_ctrl_reg;
	logic [7:0]  periph_en_reg;
	logic [7:0]  periph_flg_reg;
	logic        edge_sel_reg;
	logic        pin_prev_reg;
	logic        pc_flag_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        wr_fire;
	logic [8:0]  wr_idx;
	logic [8:0]  rd_idx;
	logic        wr_core;
	logic        wr_pen;
	logic        wr_pflg;
	logic        wr_edge;
	logic        wr_hit;
	logic        ext_edge;
	logic [7:0]  core_view;
	logic [7:0]  periph_set;
	logic [7:0]  wbyte;
	logic [7:0]  rd_val;
	logic        rd_hit;

	// Address channel and data channel held until both are present
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg;
	assign wr_idx        = aw_addr_reg[10:2];
	assign wbyte         = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end
		end
	end

	// Write address decode; all four mirrors hit the same storage
	always_comb begin
		wr_core = 1'b0;
		wr_pen  = 1'b0;
		wr_pflg = 1'b0;
		wr_edge = 1'b0;
		if (wr_idx == mie_pkg::CORE_CTRL_IDX0 ||
		    wr_idx == mie_pkg::CORE_CTRL_IDX1 ||
		    wr_idx == mie_pkg::CORE_CTRL_IDX2 ||
		    wr_idx == mie_pkg::CORE_CTRL_IDX3) begin
			wr_core = wr_fire && w_strb_reg[0];
		end else if (wr_idx == mie_pkg::PERIPH_EN_IDX) begin
			wr_pen = wr_fire && w_strb_reg[0];
		end else if (wr_idx == mie_pkg::PERIPH_FLG_IDX) begin
			wr_pflg = wr_fire && w_strb_reg[0];
		end else if (wr_idx == mie_pkg::EDGE_SEL_IDX) begin
			wr_edge = wr_fire && w_strb_reg[0];
		end
	end
	assign wr_hit = (wr_idx == mie_pkg::CORE_CTRL_IDX0) ||
		(wr_idx == mie_pkg::CORE_CTRL_IDX1) ||
		(wr_idx == mie_pkg::CORE_CTRL_IDX2) ||
		(wr_idx == mie_pkg::CORE_CTRL_IDX3) ||
		(wr_idx == mie_pkg::PERIPH_EN_IDX) ||
		(wr_idx == mie_pkg::PERIPH_FLG_IDX) ||
		(wr_idx == mie_pkg::EDGE_SEL_IDX);

	// Write response, SLVERR on unmapped address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= mie_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? mie_pkg::RESP_OKAY
				: mie_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Pin edge detect, polarity chosen by edge select
	assign ext_edge = edge_sel_reg ? (external_irq_pin && !pin_prev_reg)
		: (!external_irq_pin && pin_prev_reg);
	// The previous level starts from the pin itself, so that a pin held
	// high through reset gives no false edge when reset ends
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_prev_reg <= external_irq_pin;
			edge_sel_reg <= mie_pkg::EDGE_SEL_RST;
		end else begin
			pin_prev_reg <= external_irq_pin;
			if (wr_edge)
				edge_sel_reg <= wbyte[0];
		end
	end

	// Core control: software writes, hardware sets flags, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_ctrl_reg <= mie_pkg::CORE_CTRL_RST;
		end else begin
			if (wr_core)
				core_ctrl_reg <= wbyte;
			if (timer_zero_overflow)
				core_ctrl_reg[mie_pkg::T0F_BIT] <= 1'b1;
			if (ext_edge)
				core_ctrl_reg[mie_pkg::EXTF_BIT] <= 1'b1;
		end
	end

	// Port-change flag has no reset; it re-sets while mismatch persists
	always_ff @(posedge aclk) begin
		if (wr_core)
			pc_flag_reg <= wbyte[mie_pkg::PCF_BIT];
		if (port_mismatch)
			pc_flag_reg <= 1'b1;
	end

	assign core_view = {core_ctrl_reg[7:1], pc_flag_reg};

	// Peripheral enables, unimplemented bits forced to zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			periph_en_reg <= mie_pkg::PERIPH_RST;
		else if (wr_pen)
			periph_en_reg <= wbyte & mie_pkg::PERIPH_MASK;
	end

	// Peripheral flags at the same positions as their enables
	always_comb begin
		periph_set = 8'h00;
		periph_set[mie_pkg::ADC_BIT] = periph_evt.conv_done;
		periph_set[mie_pkg::SSP_BIT] = periph_evt.serial_port;
		periph_set[mie_pkg::CCP_BIT] = periph_evt.capture_compare;
		periph_set[mie_pkg::T2_BIT]  = periph_evt.timer_two_match;
		periph_set[mie_pkg::T1_BIT]  = periph_evt.timer_one_overflow;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			periph_flg_reg <= mie_pkg::PERIPH_RST;
		else if (wr_pflg)
			periph_flg_reg <= (wbyte | periph_set)
				& mie_pkg::PERIPH_MASK;
		else
			periph_flg_reg <= periph_flg_reg | periph_set;
	end

	// Request: global enable over core pairs and gated peripheral pairs
	always_comb begin
		irq_request = 1'b0;
		if (core_ctrl_reg[mie_pkg::GIE_BIT]) begin
			irq_request =
				(core_ctrl_reg[mie_pkg::T0E_BIT] &&
				 core_ctrl_reg[mie_pkg::T0F_BIT]) ||
				(core_ctrl_reg[mie_pkg::EXTE_BIT] &&
				 core_ctrl_reg[mie_pkg::EXTF_BIT]) ||
				(core_ctrl_reg[mie_pkg::PCE_BIT] && pc_flag_reg) ||
				(core_ctrl_reg[mie_pkg::PGATE_BIT] &&
				 |(periph_en_reg & periph_flg_reg));
		end
	end

	// Read channel, one-cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx        = s_axi_araddr[10:2];
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		if (rd_idx == mie_pkg::CORE_CTRL_IDX0 ||
		    rd_idx == mie_pkg::CORE_CTRL_IDX1 ||
		    rd_idx == mie_pkg::CORE_CTRL_IDX2 ||
		    rd_idx == mie_pkg::CORE_CTRL_IDX3) begin
			rd_val = core_view;
		end else if (rd_idx == mie_pkg::PERIPH_EN_IDX) begin
			rd_val = periph_en_reg;
		end else if (rd_idx == mie_pkg::PERIPH_FLG_IDX) begin
			rd_val = periph_flg_reg;
		end else if (rd_idx == mie_pkg::EDGE_SEL_IDX) begin
			rd_val = {7'h00, edge_sel_reg};
		end else begin
			rd_hit = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= mie_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_val};
			s_axi_rresp  <= rd_hit ? mie_pkg::RESP_OKAY
				: mie_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks on gating, flag setting and register storage
	AST_GIE_BLOCKS: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!core_ctrl_reg[mie_pkg::GIE_BIT] |-> !irq_request)
		else $error("request while global enable clear");
	AST_T0_FLAG_SET: assert property (
		@(posedge aclk) disable iff (!aresetn)
		timer_zero_overflow |=> core_ctrl_reg[mie_pkg::T0F_BIT])
		else $error("timer zero flag not set");
	AST_PC_FLAG_SET: assert property (
		@(posedge aclk) disable iff (!aresetn)
		port_mismatch |=> pc_flag_reg)
		else $error("port change flag not set");
	AST_PEN_UNIMPL: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(periph_en_reg & ~mie_pkg::PERIPH_MASK) == 8'h00)
		else $error("unimplemented enable bit set");
	AST_PGATE: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(irq_request && !core_ctrl_reg[mie_pkg::PGATE_BIT]) |->
		(core_ctrl_reg[5:3] & {core_ctrl_reg[2:1], pc_flag_reg}) != 3'h0)
		else $error("peripheral request passed closed gate");
	AST_PFLAG_SET: assert property (
		@(posedge aclk) disable iff (!aresetn)
		periph_evt.conv_done |=> periph_flg_reg[mie_pkg::ADC_BIT])
		else $error("conversion flag not set");
	// A flag may only fall through a software write
	AST_PFLAG_HOLD: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!wr_pflg |=>
		(periph_flg_reg & $past(periph_flg_reg)) == $past(periph_flg_reg))
		else $error("peripheral flag fell without a write");
	AST_MIRROR: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(wr_fire && w_strb_reg[0] && wr_idx == mie_pkg::CORE_CTRL_IDX3
		 && !timer_zero_overflow && !ext_edge) |=>
		core_ctrl_reg[7:3] == $past(wbyte[7:3]))
		else $error("mirror write lost");
	AST_EDGE_RISE: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(edge_sel_reg && $rose(external_irq_pin)) |=>
		core_ctrl_reg[mie_pkg::EXTF_BIT])
		else $error("rising edge missed");
	AST_EDGE_FALL: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(!edge_sel_reg && $fell(external_irq_pin)) |=>
		core_ctrl_reg[mie_pkg::EXTF_BIT])
		else $error("falling edge missed");
	AST_REQ_PAIR: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(core_ctrl_reg[mie_pkg::GIE_BIT] && core_ctrl_reg[mie_pkg::T0E_BIT]
		 && core_ctrl_reg[mie_pkg::T0F_BIT]) |-> irq_request)
		else $error("active pair without request");
	// Global enable, open gate and an active peripheral pair must raise the request
	AST_PERIPH_REQ: assert property (
		@(posedge aclk) disable iff (!aresetn)
		(core_ctrl_reg[mie_pkg::GIE_BIT] &&
		 core_ctrl_reg[mie_pkg::PGATE_BIT] &&
		 |(periph_en_reg & periph_flg_reg)) |-> irq_request)
		else $error("peripheral pair without request");

endmodule

// >>> tb/mie_evt_model.sv
// Event source model that drives the interrupt block's event inputs
module mie_evt_model (
	// Clock
	input  wire logic                aclk,
	// Bench commands
	input  wire logic [6:0]          fire,
	input  wire logic                pin_lvl,
	input  wire logic                port_read,
	// Event outputs
	output logic                     timer_zero_overflow,
	output logic                     external_irq_pin,
	output logic                     port_mismatch,
	output mie_pkg::mie_periph_evt_t periph_evt
);
	// One-cycle strobes and the pin level
	always_ff @(posedge aclk) begin
		periph_evt          <= fire[4:0];
		timer_zero_overflow <= fire[5];
		external_irq_pin    <= pin_lvl;
	end
	// Mismatch stays until the port is read
	always_ff @(posedge aclk) begin
		if (port_read)
			port_mismatch <= 1'b0;
		else if (fire[6])
			port_mismatch <= 1'b1;
	end
endmodule

// >>> tb/tb_mcu_interrupt_enable_flag_logic.sv
// Self-checking bench for the interrupt enable and flag block
module tb_mcu_interrupt_enable_flag_logic;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     aclk, aresetn, irq, t0, pin, pmis;
	logic [11:0]              awaddr, araddr;
	logic                     awvalid, awready, wvalid, wready;
	logic                     bvalid, bready, arvalid, arready;
	logic                     rvalid, rready, pin_lvl, port_read;
	logic [31:0]              wdata, rdata, rdv;
	logic [3:0]               wstrb;
	logic [1:0]               bresp, rresp, rs;
	logic [6:0]               fire;
	logic [7:0]               c, p, f;
	logic [8:0]               al [4];
	mie_pkg::mie_periph_evt_t pevt;
	int                       n_errors, cmp_count, cyc, b;

	mie_irq_ctrl #(.ADDR_W(12)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timer_zero_overflow(t0), .external_irq_pin(pin),
		.port_mismatch(pmis), .periph_evt(pevt), .irq_request(irq));
	mie_evt_model u_evt (.aclk(aclk), .fire(fire), .pin_lvl(pin_lvl),
		.port_read(port_read), .timer_zero_overflow(t0),
		.external_irq_pin(pin), .port_mismatch(pmis), .periph_evt(pevt));

	// Clock at 40 MHz
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// Hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Write one register byte, wait for the response
	task automatic wr(input logic [8:0] i, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {1'b0, i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	// Read one register, wait for the data
	task automatic rd_reg(input logic [8:0] i);
		@(posedge aclk);
		araddr <= {1'b0, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rdv = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// Drive events for one cycle, let flags land
	task automatic pulse(input logic [6:0] e);
		@(posedge aclk);
		fire <= e;
		@(posedge aclk);
		fire <= 7'h00;
		repeat (2) @(posedge aclk);
	endtask

	function automatic logic exp_irq(input logic [7:0] c, p, f);
		return c[7] & (|(c[5:3] & c[2:0]) | (c[6] & |(p & f & 8'h4f)));
	endfunction

	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, fire, pin_lvl} = '0;
		wstrb = 4'h1;
		port_read = 1'b1;
		al = '{mie_pkg::CORE_CTRL_IDX0, mie_pkg::CORE_CTRL_IDX1,
			mie_pkg::CORE_CTRL_IDX2, mie_pkg::CORE_CTRL_IDX3};
		void'($urandom(32'h316b));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		port_read <= 1'b0;
		rd_reg(al[0]);
		chk(rdv & 32'hfe, 32'h0);
		rd_reg(mie_pkg::PERIPH_EN_IDX);
		chk(rdv, 32'h0);
		// Every alias sees every other alias's write
		for (int k = 0; k < 4; k++) begin
			c = $urandom;
			wr(al[k], c);
			chk(rs, 2'h0);
			for (int j = 0; j < 4; j++) begin
				rd_reg(al[j]);
				chk(rdv, {24'h0, c});
			end
		end
		// Gating table, then random mixes
		for (int k = 0; k < 36; k++) begin
			c = $urandom;
			p = $urandom;
			f = $urandom;
			if (k < 20) begin
				b = (k / 4 == 4) ? 6 : k / 4;
				c = {k[1:0], 6'h00};
				p = 8'h01 << b;
				f = p;
			end
			wr(mie_pkg::PERIPH_FLG_IDX, 8'h00);
			wr(al[k % 4], c);
			wr(mie_pkg::PERIPH_EN_IDX, p);
			pulse({2'b00, f[6], f[3:0]});
			rd_reg(mie_pkg::PERIPH_FLG_IDX);
			chk(rdv, {24'h0, f & 8'h4f});
			rd_reg(mie_pkg::PERIPH_EN_IDX);
			chk(rdv, {24'h0, p & 8'h4f});
			rd_reg(al[0]);
			chk(rdv, {24'h0, c});
			chk(irq, exp_irq(c, p, f));
		end
		// Core events with everything masked
		wr(al[0], 8'h00);
		pin_lvl <= 1'b1;
		pulse(7'h60);
		rd_reg(al[0]);
		chk(rdv, 32'h07);
		wr(al[0], 8'h00);
		rd_reg(al[0]);
		chk(rdv, 32'h01);
		port_read <= 1'b1;
		@(posedge aclk);
		port_read <= 1'b0;
		wr(al[0], 8'h00);
		rd_reg(al[0]);
		chk(rdv, 32'h00);
		// Falling edge selected
		wr(mie_pkg::EDGE_SEL_IDX, 8'h00);
		pin_lvl <= 1'b0;
		pulse(7'h00);
		rd_reg(al[0]);
		chk(rdv, 32'h02);
		wr(al[0], 8'h00);
		pin_lvl <= 1'b1;
		pulse(7'h00);
		rd_reg(al[0]);
		chk(rdv, 32'h00);
		// Unmapped place
		wr(9'h1ff, 8'h5a);
		chk(rs, 2'h2);
		rd_reg(9'h1ff);
		chk(rs, 2'h2);
		conclude();
	end
endmodule
